// >>> verilog/rms_guard_defines.svh
// constants shared by the meter device end and the host controller end
`ifndef RMS_GUARD_DEFINES_SVH
`define RMS_GUARD_DEFINES_SVH
// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 10
`define LOOP_PERIOD_NS 125000
`define LOOP_CYCLES ((`LOOP_PERIOD_NS) / (`CLK_PERIOD_NS))
`define RMS_SPACING_NS 265000
`define RMS_SPACING_CYCLES ((`RMS_SPACING_NS + `CLK_PERIOD_NS - 1) / (`CLK_PERIOD_NS))
`define EVENTS_PER_RMS_READ 3
// ****************************************
// device register map
// ****************************************
`define RMS_BASE 16'h43c0
`define RMS_COUNT 7
`define APPARENT_ADDR 16'h43d0
`define ACC_KEY_ADDR 16'he7fe
`define ACC_KEY_VALUE 8'had
`define ACC_SELECT_ADDR 16'he7e2
`define ACC_SELECT_VALUE 8'h01
`define ACC_SELECT_RESET 8'h00
`define CORRUPT_MASK 32'h00ff_00ff
// ****************************************
// host csr map
// ****************************************
`define CSR_ADDR_W 4
`define CSR_CMD 4'h0
`define CSR_CFG 4'h4
`define CSR_STATUS 4'h8
`define CSR_RDATA 4'hc
`define CMD_WDATA_LSB 16
`define CMD_WRITE_BIT 24
`define CMD_ACC_BIT 25
`define CFG_PACE_EVT_BIT 0
`define STAT_BUSY_BIT 0
`define STAT_PACING_BIT 1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> verilog/rms_guard_pkg.sv
// types shared by both ends of the meter link
package rms_guard_pkg;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_pace = 2'b01,
    st_wait = 2'b10
  } host_state_type;
  typedef logic [15:0] link_addr_type;
  typedef logic [31:0] link_word_type;
endpackage : rms_guard_pkg

// >>> verilog/meter_link_if.sv
// register link between the host controller and the meter device
`timescale 1ns/10ps
interface meter_link_if;
  import rms_guard_pkg::*;
  logic req;
  logic we;
  link_addr_type addr;
  logic [7:0] wdata;
  logic ack;
  link_word_type rdata;
  logic first_interrupt_pin;
  modport dev (
    input req, we, addr, wdata,
    output ack, rdata, first_interrupt_pin
  );
  modport host (
    output req, we, addr, wdata,
    input ack, rdata, first_interrupt_pin
  );
endinterface : meter_link_if

// >>> verilog/rms_meter_device.sv
// meter device end: sample loop, rms read spacing hazard, accuracy key
`timescale 1ns/10ps
`include "rms_guard_defines.svh"
// Function
// RULE1: results recomputed once every 125 us loop
// RULE2: consecutive rms reads corrupt the second value
// RULE3: corrupted read also spoils that loop's apparent power
// RULE4: next loop recomputes correct results unaided
// RULE5: rms read starts under 265 us collide
// RULE6: only rms reads carry the spacing restriction
// RULE7: host spaces rms read starts 265 us apart
// RULE8: host may pace reads by three update events
// RULE9: host may interleave other register accesses
// RULE10: setting change starts with 0xad to 0xe7fe
// RULE11: both setting writes strictly back to back
// RULE12: select read returns 0x01 after accepted sequence
// RULE13: second write puts 0x01 at 0xe7e2
module rms_meter_device
  import rms_guard_pkg::*;
#(
  parameter int LOOP_CYCLES = `LOOP_CYCLES,
  parameter int SPACING_CYCLES = `RMS_SPACING_CYCLES,
  parameter int RMS_COUNT = `RMS_COUNT
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // host link
  meter_link_if.dev link,
  // results, channel 0 low
  input wire logic [RMS_COUNT*32-1:0] rms_in,
  input wire logic [31:0] apparent_in,
  // status
  output logic rms_corrupt_loop,
  output logic [7:0] accuracy_setting_select,
  output logic [15:0] rms_collision_count
);

  // ****************************************
  // sizes
  // ****************************************
  localparam int LW = $clog2(LOOP_CYCLES);
  localparam int GW = $clog2(SPACING_CYCLES + 1);
  localparam int IW = $clog2(RMS_COUNT + 1);
  localparam logic [LW-1:0] LOOP_LAST = LW'(LOOP_CYCLES - 1);
  localparam logic [GW-1:0] GAP_LOAD = GW'(SPACING_CYCLES); // RULE5
  localparam logic [15:0] RMS_SPAN = 16'(RMS_COUNT);

  // ****************************************
  // state
  // ****************************************
  logic [LW-1:0] loop_cnt;
  logic [GW-1:0] gap_cnt;
  logic key_armed;
  link_word_type rms_reg [RMS_COUNT];
  link_word_type apparent_reg;

  // ****************************************
  // request decode
  // ****************************************
  logic take;
  logic rd_take;
  logic wr_take;
  logic loop_wrap;
  link_addr_type rms_off;
  logic is_rms;
  logic is_apparent;
  logic is_select;
  logic is_key;
  logic [IW-1:0] rms_idx;
  logic rms_take;
  logic collide;
  logic key_hit;
  logic select_hit;
  link_word_type rms_word;
  link_word_type rms_answer;
  link_word_type read_word;
  link_word_type next_apparent;
  logic next_corrupt;

  // taken once; ack low before next
  assign take = link.req && !link.ack;
  assign rd_take = take && !link.we;
  assign wr_take = take && link.we;
  assign loop_wrap = loop_cnt == LOOP_LAST; // RULE1

  assign rms_off = link.addr - `RMS_BASE;
  assign is_rms = rms_off < RMS_SPAN;
  assign is_apparent = link.addr == `APPARENT_ADDR;
  assign is_select = link.addr == `ACC_SELECT_ADDR;
  assign is_key = link.addr == `ACC_KEY_ADDR;
  assign rms_idx = rms_off[IW-1:0];

  // only rms reads use the window
  assign rms_take = rd_take && is_rms; // RULE6
  // start inside open window collides
  assign collide = rms_take && (gap_cnt != '0); // RULE5

  // ****************************************
  // read answer
  // ****************************************
  assign rms_word = is_rms ? rms_reg[rms_idx] : 32'h0000_0000;
  assign rms_answer = collide ? (rms_word ^ `CORRUPT_MASK) : rms_word; // RULE2
  assign read_word = is_rms ? rms_answer :
                     is_apparent ? apparent_reg :
                     is_select ? {24'h00_0000, accuracy_setting_select} : // RULE12
                     32'h0000_0000;

  // ****************************************
  // accuracy setting key
  // ****************************************
  assign key_hit = wr_take && is_key && (link.wdata == `ACC_KEY_VALUE); // RULE10
  // select counts only right after key
  assign select_hit = wr_take && is_select && key_armed; // RULE11

  // ****************************************
  // loop results
  // ****************************************
  // collided loop spoils apparent power
  assign next_corrupt = rms_corrupt_loop || collide; // RULE3
  assign next_apparent = next_corrupt ? (apparent_in ^ `CORRUPT_MASK) : apparent_in; // RULE3

  // ****************************************
  // loop timer and update event
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      loop_cnt <= '0;
      link.first_interrupt_pin <= 1'b0;
    end else begin
      loop_cnt <= loop_wrap ? '0 : loop_cnt + 1'b1; // RULE1
      link.first_interrupt_pin <= loop_wrap; // RULE1
    end
  end

  // ****************************************
  // loop results capture
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < RMS_COUNT; i++) begin
        rms_reg[i] <= 32'h0000_0000;
      end
      apparent_reg <= 32'h0000_0000;
    end else if (loop_wrap) begin
      // bad read never spoils stored rms values
      for (int i = 0; i < RMS_COUNT; i++) begin
        rms_reg[i] <= rms_in[i*32 +: 32]; // RULE4
      end
      apparent_reg <= next_apparent; // RULE3
    end
  end

  // ****************************************
  // collision tracking
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rms_corrupt_loop <= 1'b0;
    end else if (loop_wrap) begin
      // set wins on the wrap cycle
      rms_corrupt_loop <= collide; // RULE4
    end else if (collide) begin
      rms_corrupt_loop <= 1'b1; // RULE3
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gap_cnt <= '0;
    end else if (rms_take) begin
      // every start reopens window
      gap_cnt <= GAP_LOAD; // RULE5
    end else if (gap_cnt != '0) begin
      gap_cnt <= gap_cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rms_collision_count <= 16'h0000;
    end else if (collide && (rms_collision_count != 16'hffff)) begin
      rms_collision_count <= rms_collision_count + 16'h0001;
    end
  end

  // ****************************************
  // accuracy setting registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      key_armed <= 1'b0;
    end else if (take) begin
      // any other access in between disarms the key
      key_armed <= key_hit; // RULE11
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      accuracy_setting_select <= `ACC_SELECT_RESET;
    end else if (select_hit) begin
      accuracy_setting_select <= link.wdata; // RULE12
    end
  end

  // ****************************************
  // link answer
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      link.ack <= 1'b0;
      link.rdata <= 32'h0000_0000;
    end else begin
      // non-rms accesses answer at once, with no spacing limit
      link.ack <= take; // RULE6
      if (rd_take) begin
        link.rdata <= read_word;
      end
    end
  end

endmodule : rms_meter_device

// >>> verilog/rms_guard_host.sv
// host end: axi4-lite csrs, rms pacing, accuracy sequence
`timescale 1ns/10ps
`include "rms_guard_defines.svh"
module rms_guard_host
  import rms_guard_pkg::*;
#(
  parameter int SPACING_CYCLES = `RMS_SPACING_CYCLES,
  parameter int EVENTS_PER_READ = `EVENTS_PER_RMS_READ,
  parameter int RMS_COUNT = `RMS_COUNT
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // axi4-lite write
  input wire logic [`CSR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [`CSR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // meter link
  meter_link_if.host link
);

  localparam int GW = $clog2(SPACING_CYCLES + 1);
  localparam int EW = $clog2(EVENTS_PER_READ + 1);
  localparam logic [GW-1:0] GAP_LOAD = GW'(SPACING_CYCLES);
  localparam logic [EW-1:0] EVT_FULL = EW'(EVENTS_PER_READ);

  // ****************************************
  // csr bus
  // ****************************************
  logic aw_full;
  logic w_full;
  logic [`CSR_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [31:0] cmd_reg;
  logic pace_evt;
  link_word_type rdata_reg;
  host_state_type state;
  logic second;
  logic [GW-1:0] gap_cnt;
  logic [EW-1:0] evt_cnt;

  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic commit;
  logic next_aw_full;
  logic next_w_full;
  logic next_bvalid;
  logic next_rvalid;
  logic hit_cmd;
  logic hit_cfg;
  logic start;
  logic wr_ok;
  logic rd_ok;
  logic [31:0] cmd_new;
  logic [31:0] cfg_new;
  logic [31:0] rd_word;

  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  // write lands with both halves held, no response pending
  assign commit = aw_full && w_full && !s_axi_bvalid;
  assign next_aw_full = (aw_full || aw_fire) && !commit;
  assign next_w_full = (w_full || w_fire) && !commit;
  assign next_bvalid = commit || (s_axi_bvalid && !s_axi_bready);
  assign next_rvalid = ar_fire || (s_axi_rvalid && !s_axi_rready);
  assign hit_cmd = aw_addr == `CSR_CMD;
  assign hit_cfg = aw_addr == `CSR_CFG;
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign cmd_new[b*8 +: 8] = w_strb[b] ? w_data[b*8 +: 8] : cmd_reg[b*8 +: 8];
    assign cfg_new[b*8 +: 8] = w_strb[b] ? w_data[b*8 +: 8] : {7'h00, pace_evt} >> (b * 8);
  end
  // command while busy: slverr
  assign start = commit && hit_cmd && (state == st_idle);
  assign wr_ok = start || hit_cfg;
  assign rd_ok = (s_axi_araddr == `CSR_CMD) || (s_axi_araddr == `CSR_CFG) ||
                 (s_axi_araddr == `CSR_STATUS) || (s_axi_araddr == `CSR_RDATA);
  assign rd_word = (s_axi_araddr == `CSR_CMD) ? cmd_reg :
                   (s_axi_araddr == `CSR_CFG) ? {31'h0000_0000, pace_evt} :
                   (s_axi_araddr == `CSR_STATUS) ? {30'h0000_0000, state == st_pace,
                                                    state != st_idle} :
                   (s_axi_araddr == `CSR_RDATA) ? rdata_reg : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      s_axi_awready <= !next_aw_full;
      s_axi_wready <= !next_w_full;
      s_axi_bvalid <= next_bvalid;
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      cmd_reg <= 32'h0000_0000;
      pace_evt <= 1'b0;
    end else begin
      if (aw_fire) aw_addr <= s_axi_awaddr;
      if (w_fire) w_data <= s_axi_wdata;
      if (w_fire) w_strb <= s_axi_wstrb;
      if (commit) s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      if (start) cmd_reg <= cmd_new;
      if (commit && hit_cfg) pace_evt <= cfg_new[`CFG_PACE_EVT_BIT];
      if (ar_fire) s_axi_rdata <= rd_word;
      if (ar_fire) s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  // ****************************************
  // pacing
  // ****************************************
  logic op_rms;
  logic pace_ok;
  logic rms_issue;
  link_addr_type op_off;

  assign op_off = cmd_new[15:0] - `RMS_BASE;
  // writes, non-rms reads skip pacing
  assign op_rms = !cmd_new[`CMD_WRITE_BIT] && !cmd_new[`CMD_ACC_BIT] &&
                  (op_off < 16'(RMS_COUNT)); // RULE9
  assign pace_ok = (gap_cnt == '0) && (!pace_evt || (evt_cnt == EVT_FULL)); // RULE7 RULE8
  assign rms_issue = (state == st_pace) && pace_ok;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gap_cnt <= '0;
      evt_cnt <= EVT_FULL;
    end else begin
      if (rms_issue) gap_cnt <= GAP_LOAD; // RULE7
      else if (gap_cnt != '0) gap_cnt <= gap_cnt - 1'b1;
      // issue-cycle event counts for next read
      if (rms_issue) evt_cnt <= EW'(link.first_interrupt_pin); // RULE8
      else if (link.first_interrupt_pin && (evt_cnt != EVT_FULL)) evt_cnt <= evt_cnt + 1'b1;
    end
  end

  // ****************************************
  // link sequencer
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= st_idle;
      second <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      link.req <= 1'b0;
      link.we <= 1'b0;
      link.addr <= 16'h0000;
      link.wdata <= 8'h00;
    end else begin
      case (state)
        st_idle: begin
          if (start) begin
            second <= cmd_new[`CMD_ACC_BIT];
            if (cmd_new[`CMD_ACC_BIT]) begin
              link.we <= 1'b1;
              link.addr <= `ACC_KEY_ADDR; // RULE10
              link.wdata <= `ACC_KEY_VALUE; // RULE10
            end else begin
              link.we <= cmd_new[`CMD_WRITE_BIT];
              link.addr <= cmd_new[15:0];
              link.wdata <= cmd_new[`CMD_WDATA_LSB +: 8];
            end
            link.req <= !op_rms;
            state <= op_rms ? st_pace : st_wait;
          end
        end
        st_pace: begin
          if (pace_ok) begin
            link.req <= 1'b1; // RULE7
            state <= st_wait;
          end
        end
        st_wait: begin
          if (link.ack) begin
            if (!link.we) rdata_reg <= link.rdata;
            if (second) begin
              // req stays high between the writes
              second <= 1'b0;
              link.addr <= `ACC_SELECT_ADDR; // RULE11 RULE13
              link.wdata <= `ACC_SELECT_VALUE; // RULE13
            end else begin
              link.req <= 1'b0;
              state <= st_idle;
            end
          end
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

endmodule : rms_guard_host

// >>> tb/rms_guard_chk.sv
// link checker: answer timing, update events, rms spacing, accuracy key
`timescale 1ns/10ps
`include "rms_guard_defines.svh"
module rms_guard_chk
  import rms_guard_pkg::*;
#(
  parameter int LOOP_CYCLES = 50,
  parameter int SPACING_CYCLES = 120
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // link signals
  input wire logic req,
  input wire logic we,
  input wire link_addr_type addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire link_word_type rdata,
  input wire logic first_interrupt_pin
);
  logic take;
  logic rms_take;
  logic armed;
  logic [7:0] sel;
  logic [15:0] gap;
  assign take = req && !ack;
  assign rms_take = take && !we && (addr - `RMS_BASE) < 16'(`RMS_COUNT);
  // saturated at reset: first rms read free
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gap <= 16'(SPACING_CYCLES);
      armed <= 1'b0;
      sel <= `ACC_SELECT_RESET;
    end else begin
      if (rms_take) gap <= 16'h0001;
      else if (gap < 16'(SPACING_CYCLES)) gap <= gap + 16'h0001;
      if (take) armed <= we && addr == `ACC_KEY_ADDR && wdata == `ACC_KEY_VALUE;
      if (take && armed && we && addr == `ACC_SELECT_ADDR) sel <= wdata;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_key; take && we && addr == `ACC_KEY_ADDR && wdata == `ACC_KEY_VALUE; endsequence
  sequence s_sel; take && we && addr == `ACC_SELECT_ADDR && wdata == `ACC_SELECT_VALUE; endsequence
  property p_ack_after_take; take |=> ack; endproperty
  a_ack_after_take: assert property (p_ack_after_take) else $error("no answer after take");
  property p_ack_pulse; ack |=> !ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("answer longer than one cycle");
  property p_req_hold; take |=> req && $stable(addr) && $stable(we) && $stable(wdata); endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped before answer");
  property p_evt_period; first_interrupt_pin |-> ##LOOP_CYCLES first_interrupt_pin; endproperty
  a_evt_period: assert property (p_evt_period) else $error("update event period wrong");
  property p_evt_gap; first_interrupt_pin |=> !first_interrupt_pin [*8]; endproperty
  a_evt_gap: assert property (p_evt_gap) else $error("update event repeated early");
  property p_rms_spacing; rms_take |-> gap == 16'(SPACING_CYCLES); endproperty
  a_rms_spacing: assert property (p_rms_spacing) else $error("rms reads too close");
  property p_key_pair; s_key |-> ##2 s_sel; endproperty
  a_key_pair: assert property (p_key_pair) else $error("key not followed by select");
  property p_key_value; take && we && addr == `ACC_KEY_ADDR |-> wdata == `ACC_KEY_VALUE; endproperty
  a_key_value: assert property (p_key_value) else $error("wrong key byte");
  property p_sel_value; s_key ##2 take && we |-> wdata == `ACC_SELECT_VALUE; endproperty
  a_sel_value: assert property (p_sel_value) else $error("wrong select byte");
  property p_sel_read; take && !we && addr == `ACC_SELECT_ADDR |=> rdata == {24'h0, sel}; endproperty
  a_sel_read: assert property (p_sel_read) else $error("select read back wrong");
endmodule : rms_guard_chk

// >>> tb/testbench.sv
// bench: host to device, plus a directly driven second device
`timescale 1ns/10ps
`include "rms_guard_defines.svh"
module testbench;
  import rms_guard_pkg::*;
  localparam int LOOP = 50;
  localparam int SPACE = 120;
  localparam link_word_type APP = 32'h7e57_a110;
  typedef struct {
    logic [31:0] cmd;
    logic [31:0] exp;
  } row_type;
  logic clk = 1'b0, sys_rst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, corr_a, corr_b;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [`RMS_COUNT*32-1:0] rms_in;
  logic [7:0] sel_a, sel_b;
  logic [15:0] cnt_a, cnt_b;
  int error_cnt = 0, checks = 0, evts = 0, evt_at_take = 0;
  row_type rows[6];
  meter_link_if lnk ();
  meter_link_if lnk_b ();
  rms_meter_device #(.LOOP_CYCLES(LOOP), .SPACING_CYCLES(SPACE)) i_rms_meter_device (
    .clk(clk), .sys_rst(sys_rst), .link(lnk.dev), .rms_in(rms_in), .apparent_in(APP),
    .rms_corrupt_loop(corr_a), .accuracy_setting_select(sel_a), .rms_collision_count(cnt_a));
  // second device: rules broken on purpose
  rms_meter_device #(.LOOP_CYCLES(LOOP), .SPACING_CYCLES(SPACE)) i_rms_meter_device_b (
    .clk(clk), .sys_rst(sys_rst), .link(lnk_b.dev), .rms_in(rms_in), .apparent_in(APP),
    .rms_corrupt_loop(corr_b), .accuracy_setting_select(sel_b), .rms_collision_count(cnt_b));
  rms_guard_host #(.SPACING_CYCLES(SPACE)) i_rms_guard_host (
    .clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link(lnk.host));
  rms_guard_chk #(.LOOP_CYCLES(LOOP), .SPACING_CYCLES(SPACE)) i_rms_guard_chk (
    .clk(clk), .sys_rst(sys_rst), .req(lnk.req), .we(lnk.we), .addr(lnk.addr),
    .wdata(lnk.wdata), .ack(lnk.ack), .rdata(lnk.rdata),
    .first_interrupt_pin(lnk.first_interrupt_pin));
  initial forever #5 clk = ~clk;
  // events since last rms take
  always @(posedge clk) begin
    if (lnk.req && !lnk.ack && !lnk.we && lnk.addr[15:4] == 12'h43c) begin
      evt_at_take <= evts;
      evts <= int'(lnk.first_interrupt_pin);
    end else if (lnk.first_interrupt_pin) begin
      evts <= evts + 1;
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  function automatic link_word_type rms_v(input int i);
    return 32'h5a5a_0000 + 32'(i);
  endfunction : rms_v
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic final_report;
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  task automatic give_up;
    error_cnt++;
    final_report();
  endtask : give_up
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
    int n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    if (!bvalid) give_up();
    resp = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask : axi_write
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    if (!rvalid) give_up();
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : axi_read
  task automatic wait_done(output logic [31:0] rd);
    logic [1:0] r;
    int n = 0;
    do begin
      axi_read(`CSR_STATUS, rd, r);
      n++;
    end while (rd[`STAT_BUSY_BIT] && n < 300);
    if (rd[`STAT_BUSY_BIT] !== 1'b0) give_up();
    axi_read(`CSR_RDATA, rd, r);
  endtask : wait_done
  task automatic host_op(input logic [31:0] cmd, output logic [31:0] rd);
    logic [1:0] r;
    axi_write(`CSR_CMD, cmd, r);
    wait_done(rd);
  endtask : host_op
  // req held between calls: back to back
  task automatic op_b(input logic w, input link_addr_type a, input logic [7:0] d,
                      output link_word_type rd);
    int n = 0;
    lnk_b.req <= 1'b1;
    lnk_b.we <= w;
    lnk_b.addr <= a;
    lnk_b.wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (!lnk_b.ack && n < 10);
    if (!lnk_b.ack) give_up();
    rd = lnk_b.rdata;
  endtask : op_b
  task automatic idle_b;
    lnk_b.req <= 1'b0;
    @(posedge clk);
  endtask : idle_b
  task automatic wait_evt_b;
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!lnk_b.first_interrupt_pin && n < 200);
    if (!lnk_b.first_interrupt_pin) give_up();
  endtask : wait_evt_b
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    logic [31:0] rd;
    logic [1:0] r;
    lnk_b.req = 1'b0;
    lnk_b.we = 1'b0;
    lnk_b.addr = 16'h0000;
    lnk_b.wdata = 8'h00;
    for (int i = 0; i < `RMS_COUNT; i++) rms_in[i*32+:32] = rms_v(i);
    rows = '{'{32'h43c0, rms_v(0)}, '{32'h43c6, rms_v(6)}, '{32'h43d0, APP},
             '{32'h123, 32'h0}, '{32'he7e2, 32'h0}, '{32'h43c3, rms_v(3)}};
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (LOOP + 2) @(posedge clk);
    foreach (rows[i]) begin
      host_op(rows[i].cmd, rd);
      check("host read", rd, rows[i].exp);
    end
    axi_write(`CSR_CMD, 32'h43c1, r);
    axi_read(`CSR_STATUS, rd, r);
    check("status", 32'(rd[1:0]), 32'h3);
    axi_write(`CSR_CMD, 32'h43c2, r);
    check("busy resp", 32'(r), 32'(`RESP_SLVERR));
    wait_done(rd);
    check("paced read", rd, rms_v(1));
    axi_read(4'h2, rd, r);
    check("unmapped resp", 32'(r), 32'(`RESP_SLVERR));
    axi_write(`CSR_CFG, 32'h1, r);
    axi_read(`CSR_CFG, rd, r);
    check("cfg", rd, 32'h1);
    host_op(32'h43c4, rd);
    host_op(32'h43c5, rd);
    check("event paced read", rd, rms_v(5));
    check("events between", 32'(evt_at_take >= 3), 32'h1);
    check("collisions", 32'(cnt_a), 32'h0);
    host_op(32'h0200_0000, rd);
    check("select", 32'(sel_a), 32'h1);
    host_op(32'he7e2, rd);
    check("select read", rd, 32'h1);
    wait_evt_b();
    op_b(1'b0, 16'h43c0, 8'h00, rd);
    check("first rms", rd, rms_v(0));
    op_b(1'b0, 16'h43c1, 8'h00, rd);
    check("second rms", rd, rms_v(1) ^ `CORRUPT_MASK);
    idle_b();
    check("corrupt flag", 32'(corr_b), 32'h1);
    check("collision count", 32'(cnt_b), 32'h1);
    wait_evt_b();
    op_b(1'b0, `APPARENT_ADDR, 8'h00, rd);
    check("apparent spoiled", rd, APP ^ `CORRUPT_MASK);
    idle_b();
    wait_evt_b();
    op_b(1'b0, `APPARENT_ADDR, 8'h00, rd);
    check("apparent recovered", rd, APP);
    check("corrupt cleared", 32'(corr_b), 32'h0);
    idle_b();
    repeat (SPACE) @(posedge clk);
    op_b(1'b0, 16'h43c2, 8'h00, rd);
    for (int i = 0; i < SPACE / 2 + 1; i++) op_b(1'b0, 16'he7e2, 8'h00, rd);
    op_b(1'b0, 16'h43c4, 8'h00, rd);
    check("interleaved rms", rd, rms_v(4));
    check("count kept", 32'(cnt_b), 32'h1);
    op_b(1'b1, `ACC_KEY_ADDR, `ACC_KEY_VALUE, rd);
    op_b(1'b0, `APPARENT_ADDR, 8'h00, rd);
    op_b(1'b1, `ACC_SELECT_ADDR, `ACC_SELECT_VALUE, rd);
    idle_b();
    check("split sequence", 32'(sel_b), 32'h0);
    op_b(1'b1, `ACC_KEY_ADDR, `ACC_KEY_VALUE, rd);
    op_b(1'b1, `ACC_SELECT_ADDR, `ACC_SELECT_VALUE, rd);
    op_b(1'b0, `ACC_SELECT_ADDR, 8'h00, rd);
    idle_b();
    check("select b read", rd, 32'h1);
    check("select b", 32'(sel_b), 32'h1);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check("select after reset", 32'(sel_a), 32'(`ACC_SELECT_RESET));
    final_report();
  end
endmodule : testbench
